// ==== pkg/cta_pkg.sv ====
/*
 * Constants and types shared by the critical temperature alarm status block.
 * Assumes a 32-bit classic Wishbone register bus and word-aligned registers.
 */
package cta_pkg;

    // Number of monitored channels: local plus four remote diodes.
    localparam int NUM_CH = 5;
    // Width of a temperature reading, limit and hysteresis value.
    localparam int TEMP_W = 8;

    // Channel bit positions inside both alarm status registers.
    localparam int BIT_LOCAL = 0;
    localparam int BIT_REM1  = 1;
    localparam int BIT_REM2  = 2;
    localparam int BIT_REM3  = 3;
    localparam int BIT_REM4  = 4;

    // Register indexes; the byte address is four times the index.
    localparam logic [5:0] IDX_COMMON_STATUS = 6'h02;
    localparam logic [5:0] IDX_ALARM_ONE     = 6'h08;
    localparam logic [5:0] IDX_ALARM_TWO     = 6'h09;
    localparam logic [5:0] IDX_MASK_ONE      = 6'h0C;
    localparam logic [5:0] IDX_MASK_TWO      = 6'h0D;
    localparam logic [5:0] IDX_LIM_LOCAL     = 6'h10;
    localparam logic [5:0] IDX_LIM_REM1_ONE  = 6'h11;
    localparam logic [5:0] IDX_LIM_REM2_ONE  = 6'h12;
    localparam logic [5:0] IDX_LIM_REM3      = 6'h13;
    localparam logic [5:0] IDX_LIM_REM4      = 6'h14;
    localparam logic [5:0] IDX_LIM_REM1_TWO  = 6'h15;
    localparam logic [5:0] IDX_LIM_REM2_TWO  = 6'h16;
    localparam logic [5:0] IDX_HYST          = 6'h17;
    localparam logic [5:0] IDX_IRQ_STATUS    = 6'h18;
    localparam logic [5:0] IDX_IRQ_MASK      = 6'h19;

    // Summary flag positions in the common status register.
    localparam int SUM_ALARM_ONE = 1;
    localparam int SUM_ALARM_TWO = 2;

    // Values after reset.
    localparam logic [4:0]        RST_MASK_ONE = 5'h19;
    localparam logic [4:0]        RST_MASK_TWO = 5'h00;
    localparam logic [TEMP_W-1:0] RST_LIMIT    = 8'h7F;
    localparam logic [TEMP_W-1:0] RST_HYST     = 8'h0A;
    localparam logic [9:0]        RST_IRQ_MASK = 10'h000;

    // Readings from the converter, one per channel, with a done strobe each.
    typedef struct packed {
        logic [NUM_CH-1:0][TEMP_W-1:0] reading;
        logic [NUM_CH-1:0]             done;
    } cta_conv_t;

    // One Wishbone request as the slave sees it.
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } cta_wb_req_t;

endpackage : cta_pkg

// ==== src/cta_alarm_status.sv ====
/*
 * Critical temperature alarm status logic with a Wishbone register slave.
 * Holds two alarm status registers, their masks, the limits, the shared
 * hysteresis and a read-to-clear interrupt status.
 * Assumes readings arrive from converter logic on the same clock, each with
 * a one-cycle done strobe after a completed conversion of its channel.
 */
// Implementation choice: the Wishbone register port.
// Behaviour
// - The first alarm output asserts while any unmasked bit of its status register is set.
// - The first alarm output releases when every unmasked bit of its status register is zero.
// - The second alarm output asserts while any unmasked bit of its own status register is set.
// - The second alarm output releases when every unmasked bit of its own status register is clear.
// - Bits 7 to 5 of both alarm status registers read zero and both registers are read-only.
// - The local bit 0 sets when the local reading is at or above the local limit.
// - The local bit clears only when the local reading is below limit minus hysteresis.
// - The remote 4 bit 4 sets when the remote 4 reading is at or above its limit.
// - The remote 4 bit clears only when its reading is below limit minus hysteresis.
// - The remote 3 bit 3 sets at or above its limit and clears below limit minus hysteresis.
// - For alarm one, remote 2 bit 2 uses the first remote 2 limit with hysteresis on clear.
// - For alarm two, remote 2 uses its separate second limit with hysteresis on clear.
// - For alarm one, remote 1 bit 1 uses the first remote 1 limit with hysteresis on clear.
// - For alarm two, remote 1 uses its separate second limit with hysteresis on clear.
// - The common status register shows a flag for each alarm register with any bit set.
module cta_alarm_status
    import cta_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    input  wire cta_pkg::cta_conv_t conv_i,
    output logic                   crit_alarm_one_n_o,
    output logic                   crit_alarm_two_n_o,
    output logic                   irq_o
);
    import cta_pkg::*;

    // Next value of one status bit; comparing reading plus hysteresis with
    // the limit avoids the underflow that limit minus hysteresis would hit.
    function automatic logic hyst_bit(input logic              cur,
                                      input logic [TEMP_W-1:0] rd,
                                      input logic [TEMP_W-1:0] lim,
                                      input logic [TEMP_W-1:0] hy);
        logic [TEMP_W:0] sum;
        sum = {1'b0, rd} + {1'b0, hy};
        if (rd >= lim)
            hyst_bit = 1'b1;
        else if (sum < {1'b0, lim})
            hyst_bit = 1'b0;
        else
            hyst_bit = cur;
    endfunction

    // Software registers.
    logic [4:0]        mask_one_ff;
    logic [4:0]        mask_two_ff;
    logic [TEMP_W-1:0] lim_local_ff;
    logic [TEMP_W-1:0] lim_rem1_one_ff;
    logic [TEMP_W-1:0] lim_rem2_one_ff;
    logic [TEMP_W-1:0] lim_rem3_ff;
    logic [TEMP_W-1:0] lim_rem4_ff;
    logic [TEMP_W-1:0] lim_rem1_two_ff;
    logic [TEMP_W-1:0] lim_rem2_two_ff;
    logic [TEMP_W-1:0] hyst_ff;
    logic [9:0]        irq_mask_ff;

    // Block state.
    logic [4:0]        alarm_one_ff;
    logic [4:0]        alarm_two_ff;
    logic [4:0]        nxt_alarm_one;
    logic [4:0]        nxt_alarm_two;
    logic [9:0]        irq_stat_ff;
    logic [9:0]        nxt_irq_stat;
    logic [31:0]       dat_ff;
    logic              ack_ff;
    logic              alarm_one_n_ff;
    logic              alarm_two_n_ff;
    logic              irq_ff;

    // Bus decode: a request is taken in the cycle before ack rises.
    logic              req_take;
    logic              wr_take;
    logic              rd_take;
    logic              lane0_wr;
    logic [5:0]        idx;
    logic [31:0]       rd_data;
    logic [9:0]        rise_evt;
    logic              rd_irq_clear;

    assign req_take     = wb_cyc_i & wb_stb_i & ~ack_ff;
    assign wr_take      = req_take & wb_we_i;
    assign rd_take      = req_take & ~wb_we_i;
    assign lane0_wr     = wr_take & wb_sel_i[0];
    assign idx          = wb_adr_i[7:2];
    assign rd_irq_clear = rd_take & (idx == IDX_IRQ_STATUS);

    // Status bit evaluation per channel; each bit is only touched after the
    // done strobe of its own channel, so stale readings never move a bit.
    always_comb begin
        nxt_alarm_one = alarm_one_ff;
        nxt_alarm_two = alarm_two_ff;
        if (conv_i.done[BIT_LOCAL]) begin
            nxt_alarm_one[BIT_LOCAL] = hyst_bit(alarm_one_ff[BIT_LOCAL],
                conv_i.reading[BIT_LOCAL], lim_local_ff, hyst_ff);
            nxt_alarm_two[BIT_LOCAL] = hyst_bit(alarm_two_ff[BIT_LOCAL],
                conv_i.reading[BIT_LOCAL], lim_local_ff, hyst_ff);
        end
        if (conv_i.done[BIT_REM1]) begin
            nxt_alarm_one[BIT_REM1] = hyst_bit(alarm_one_ff[BIT_REM1],
                conv_i.reading[BIT_REM1], lim_rem1_one_ff, hyst_ff);
            nxt_alarm_two[BIT_REM1] = hyst_bit(alarm_two_ff[BIT_REM1],
                conv_i.reading[BIT_REM1], lim_rem1_two_ff, hyst_ff);
        end
        if (conv_i.done[BIT_REM2]) begin
            nxt_alarm_one[BIT_REM2] = hyst_bit(alarm_one_ff[BIT_REM2],
                conv_i.reading[BIT_REM2], lim_rem2_one_ff, hyst_ff);
            nxt_alarm_two[BIT_REM2] = hyst_bit(alarm_two_ff[BIT_REM2],
                conv_i.reading[BIT_REM2], lim_rem2_two_ff, hyst_ff);
        end
        if (conv_i.done[BIT_REM3]) begin
            nxt_alarm_one[BIT_REM3] = hyst_bit(alarm_one_ff[BIT_REM3],
                conv_i.reading[BIT_REM3], lim_rem3_ff, hyst_ff);
            nxt_alarm_two[BIT_REM3] = hyst_bit(alarm_two_ff[BIT_REM3],
                conv_i.reading[BIT_REM3], lim_rem3_ff, hyst_ff);
        end
        if (conv_i.done[BIT_REM4]) begin
            nxt_alarm_one[BIT_REM4] = hyst_bit(alarm_one_ff[BIT_REM4],
                conv_i.reading[BIT_REM4], lim_rem4_ff, hyst_ff);
            nxt_alarm_two[BIT_REM4] = hyst_bit(alarm_two_ff[BIT_REM4],
                conv_i.reading[BIT_REM4], lim_rem4_ff, hyst_ff);
        end
    end

    // Interrupt events are rising edges of any alarm status bit; a new event
    // in the same cycle as the clearing read is kept, so the set wins.
    assign rise_evt     = {nxt_alarm_two & ~alarm_two_ff, nxt_alarm_one & ~alarm_one_ff};
    assign nxt_irq_stat = (rd_irq_clear ? 10'h000 : irq_stat_ff) | rise_evt;

    // Read multiplexer; unmapped indexes and unused upper bits read zero.
    always_comb begin
        rd_data = 32'h0000_0000;
        case (idx)
            IDX_COMMON_STATUS: begin
                rd_data[SUM_ALARM_ONE] = |alarm_one_ff;
                rd_data[SUM_ALARM_TWO] = |alarm_two_ff;
            end
            IDX_ALARM_ONE:    rd_data[4:0] = alarm_one_ff;
            IDX_ALARM_TWO:    rd_data[4:0] = alarm_two_ff;
            IDX_MASK_ONE:     rd_data[4:0] = mask_one_ff;
            IDX_MASK_TWO:     rd_data[4:0] = mask_two_ff;
            IDX_LIM_LOCAL:    rd_data[TEMP_W-1:0] = lim_local_ff;
            IDX_LIM_REM1_ONE: rd_data[TEMP_W-1:0] = lim_rem1_one_ff;
            IDX_LIM_REM2_ONE: rd_data[TEMP_W-1:0] = lim_rem2_one_ff;
            IDX_LIM_REM3:     rd_data[TEMP_W-1:0] = lim_rem3_ff;
            IDX_LIM_REM4:     rd_data[TEMP_W-1:0] = lim_rem4_ff;
            IDX_LIM_REM1_TWO: rd_data[TEMP_W-1:0] = lim_rem1_two_ff;
            IDX_LIM_REM2_TWO: rd_data[TEMP_W-1:0] = lim_rem2_two_ff;
            IDX_HYST:         rd_data[TEMP_W-1:0] = hyst_ff;
            IDX_IRQ_STATUS:   rd_data[9:0] = irq_stat_ff;
            IDX_IRQ_MASK:     rd_data[9:0] = irq_mask_ff;
            default:          rd_data = 32'h0000_0000;
        endcase
    end

    // Bus handshake: ack follows a request by one cycle and drops after one.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            dat_ff <= 32'h0000_0000;
        end else begin
            ack_ff <= req_take;
            dat_ff <= rd_take ? rd_data : 32'h0000_0000;
        end
    end

    // Writable registers; writes to the status registers fall through the
    // decode and are ignored, which keeps them read-only.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_one_ff     <= RST_MASK_ONE;
            mask_two_ff     <= RST_MASK_TWO;
            lim_local_ff    <= RST_LIMIT;
            lim_rem1_one_ff <= RST_LIMIT;
            lim_rem2_one_ff <= RST_LIMIT;
            lim_rem3_ff     <= RST_LIMIT;
            lim_rem4_ff     <= RST_LIMIT;
            lim_rem1_two_ff <= RST_LIMIT;
            lim_rem2_two_ff <= RST_LIMIT;
            hyst_ff         <= RST_HYST;
        end else if (lane0_wr) begin
            case (idx)
                IDX_MASK_ONE:     mask_one_ff     <= wb_dat_i[4:0];
                IDX_MASK_TWO:     mask_two_ff     <= wb_dat_i[4:0];
                IDX_LIM_LOCAL:    lim_local_ff    <= wb_dat_i[TEMP_W-1:0];
                IDX_LIM_REM1_ONE: lim_rem1_one_ff <= wb_dat_i[TEMP_W-1:0];
                IDX_LIM_REM2_ONE: lim_rem2_one_ff <= wb_dat_i[TEMP_W-1:0];
                IDX_LIM_REM3:     lim_rem3_ff     <= wb_dat_i[TEMP_W-1:0];
                IDX_LIM_REM4:     lim_rem4_ff     <= wb_dat_i[TEMP_W-1:0];
                IDX_LIM_REM1_TWO: lim_rem1_two_ff <= wb_dat_i[TEMP_W-1:0];
                IDX_LIM_REM2_TWO: lim_rem2_two_ff <= wb_dat_i[TEMP_W-1:0];
                IDX_HYST:         hyst_ff         <= wb_dat_i[TEMP_W-1:0];
                default:          hyst_ff         <= hyst_ff;
            endcase
        end
    end

    // Interrupt mask sits in the two low byte lanes since it is ten bits.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_mask_ff <= RST_IRQ_MASK;
        end else if (wr_take && idx == IDX_IRQ_MASK) begin
            if (wb_sel_i[0])
                irq_mask_ff[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1])
                irq_mask_ff[9:8] <= wb_dat_i[9:8];
        end
    end

    // Alarm status and interrupt status.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            alarm_one_ff <= 5'h00;
            alarm_two_ff <= 5'h00;
            irq_stat_ff  <= 10'h000;
        end else begin
            alarm_one_ff <= nxt_alarm_one;
            alarm_two_ff <= nxt_alarm_two;
            irq_stat_ff  <= nxt_irq_stat;
        end
    end

    // Output pins are registered; the alarm pins trail the status bits by one cycle, irq_o does not;
    // the mask only gates the pin, never the status bit itself.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            alarm_one_n_ff <= 1'b1;
            alarm_two_n_ff <= 1'b1;
            irq_ff         <= 1'b0;
        end else begin
            alarm_one_n_ff <= ~|(alarm_one_ff & ~mask_one_ff);
            alarm_two_n_ff <= ~|(alarm_two_ff & ~mask_two_ff);
            irq_ff         <= |(nxt_irq_stat & ~irq_mask_ff);
        end
    end

    assign wb_dat_o           = dat_ff;
    assign wb_ack_o           = ack_ff;
    assign crit_alarm_one_n_o = alarm_one_n_ff;
    assign crit_alarm_two_n_o = alarm_two_n_ff;
    assign irq_o              = irq_ff;

endmodule // cta_alarm_status

// ==== verif/cta_alarm_status_properties.sv ====
/* Concurrent checks on the ports of the alarm status block.
   Assumes one clock and a synchronous, active-high reset. */
module cta_alarm_status_properties
    import cta_pkg::*;
(
    input wire logic               clk_i,
    input wire logic               rst_i,
    input wire logic               wb_cyc_i,
    input wire logic               wb_stb_i,
    input wire logic               wb_we_i,
    input wire logic [7:0]         wb_adr_i,
    input wire logic [3:0]         wb_sel_i,
    input wire logic [31:0]        wb_dat_i,
    input wire logic [31:0]        wb_dat_o,
    input wire logic               wb_ack_o,
    input wire cta_pkg::cta_conv_t conv_i,
    input wire logic               crit_alarm_one_n_o,
    input wire logic               crit_alarm_two_n_o,
    input wire logic               irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // A taken request, anything that may move status or masks, and a status read.
    wire logic take  = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire logic cause = take || (|conv_i.done);
    wire logic s_rd  = take && !wb_we_i && (wb_adr_i[7:2] == IDX_ALARM_ONE ||
                       wb_adr_i[7:2] == IDX_ALARM_TWO);
    // The answer is a single-cycle acknowledge.
    sequence s_answer;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    a_ack_latency: assert property (take |=> s_answer)
        else $error("acknowledge did not follow the request by one cycle");
    a_ack_cause: assert property (wb_ack_o |-> $past(take))
        else $error("acknowledge without a request");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside acknowledge");
    a_status_upper: assert property (s_rd |=> wb_dat_o[31:5] == 27'h0)
        else $error("status register upper bits not zero");
    a_reset_idle: assert property ($fell(rst_i) |-> crit_alarm_one_n_o &&
        crit_alarm_two_n_o && !irq_o && !wb_ack_o)
        else $error("outputs not idle after reset");
    a_alarm_one_cause: assert property ($changed(crit_alarm_one_n_o) |->
        $past(cause) || $past(cause, 2))
        else $error("first alarm moved without a conversion or write");
    a_alarm_two_cause: assert property ($changed(crit_alarm_two_n_o) |->
        $past(cause) || $past(cause, 2))
        else $error("second alarm moved without a conversion or write");
    a_irq_cause: assert property ($changed(irq_o) |-> $past(cause) || $past(cause, 2))
        else $error("interrupt moved without a cause");
endmodule : cta_alarm_status_properties

bind cta_alarm_status cta_alarm_status_properties i_cta_alarm_status_properties (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .conv_i, .crit_alarm_one_n_o, .crit_alarm_two_n_o, .irq_o);

// ==== verif/cta_conv_model.sv ====
/* Converter model that hands one finished reading at a time to the block.
   Assumes the bench requests a conversion with a one-cycle start pulse. */
module cta_conv_model
    import cta_pkg::*;
(
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         start_i,
    input  wire logic [2:0]   ch_i,
    input  wire logic [7:0]   temp_i,
    output cta_pkg::cta_conv_t conv_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Results stand like result registers; done is a one-cycle pulse per conversion.
    always_ff @(posedge clk_i) begin
        conv_o.done <= '0;
        if (rst_i) begin
            conv_o.reading <= '0;
        end else if (start_i) begin
            conv_o.reading[ch_i] <= temp_i;
            conv_o.done[ch_i]    <= 1'b1;
        end
    end
endmodule : cta_conv_model

// ==== verif/cta_alarm_status_tb_top.sv ====
/* Self-checking bench for the alarm status block: registers, alarms, interrupt.
   Assumes the package, converter model and checker are compiled before it. */
module cta_alarm_status_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import cta_pkg::*;
    localparam logic [7:0] CORNER [5] = '{8'h7F, 8'h75, 8'h74, 8'h7E, 8'h80};
    logic clk, rst, start, ack, al1_n, al2_n, irq;
    logic [2:0] ch;
    logic [7:0] temp, v, hy, lim1 [5], lim2 [5];
    logic [4:0] st1, st2, m1, m2;
    logic [9:0] irqs, irqm;
    logic [15:0] rnd;
    logic [31:0] rdat, dat_o;
    cta_wb_req_t req;
    cta_conv_t conv;
    int errors, total_checks, i, c;

    cta_conv_model i_cta_conv_model (.clk_i(clk), .rst_i(rst), .start_i(start),
        .ch_i(ch), .temp_i(temp), .conv_o(conv));
    cta_alarm_status i_cta_alarm_status (.clk_i(clk), .rst_i(rst), .wb_cyc_i(req.cyc),
        .wb_stb_i(req.stb), .wb_we_i(req.we), .wb_adr_i(req.adr), .wb_sel_i(req.sel),
        .wb_dat_i(req.dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .conv_i(conv),
        .crit_alarm_one_n_o(al1_n), .crit_alarm_two_n_o(al2_n), .irq_o(irq));

    // Free-running 40 MHz clock.
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    function automatic logic [15:0] lfsr(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Expected status bit; inside the band it keeps its old value.
    function automatic logic next_bit(logic old, logic [7:0] rd, logic [7:0] lim);
        if (rd >= lim) return 1'b1;
        if ({1'b0, rd} + {1'b0, hy} < {1'b0, lim}) return 1'b0;
        return old;
    endfunction

    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // One classic cycle; the request holds until ack is sampled high.
    task automatic wb(logic w, logic [5:0] idx, logic [31:0] d);
        int n;
        req <= '{1'b1, 1'b1, w, {idx, 2'b00}, 4'hF, d};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) begin
            errors++;
            end_of_test();
        end
        rdat = dat_o;
        req <= '0;
        @(posedge clk);
    endtask
    task automatic rdchk(string what, logic [5:0] idx, logic [31:0] exp);
        wb(1'b0, idx, 32'h0);
        chk(what, rdat, exp);
    endtask
    // One conversion on channel k, then pins, status, summary and interrupt.
    task automatic step(logic [2:0] k, logic [7:0] t);
        logic [4:0] o1, o2;
        o1 = st1;
        o2 = st2;
        ch <= k;
        temp <= t;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        repeat (4) @(posedge clk);
        st1[k] = next_bit(o1[k], t, lim1[k]);
        st2[k] = next_bit(o2[k], t, lim2[k]);
        irqs = irqs | {st2 & ~o2, st1 & ~o1};
        chk("alarm_one_n", al1_n, ~|(st1 & ~m1));
        chk("alarm_two_n", al2_n, ~|(st2 & ~m2));
        chk("irq", irq, |(irqs & ~irqm));
        rdchk("status_one", IDX_ALARM_ONE, st1);
        rdchk("status_two", IDX_ALARM_TWO, st2);
        wb(1'b0, IDX_COMMON_STATUS, 32'h0);
        chk("summary", rdat & 32'h6, {|st2, |st1, 1'b0});
        rdchk("irq_status", IDX_IRQ_STATUS, irqs);
        irqs = '0;
        chk("irq_cleared", irq, 1'b0);
    endtask

    // Reset, register defaults, boundary walk, then random readings.
    initial begin
        rst = 1'b1;
        req = '0;
        start = 1'b0;
        ch = '0;
        temp = '0;
        errors = 0;
        total_checks = 0;
        rnd = 16'h0495;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (c = 0; c < 7; c++) rdchk("limit", IDX_LIM_LOCAL + 6'(c), RST_LIMIT);
        rdchk("mask_one", IDX_MASK_ONE, RST_MASK_ONE);
        rdchk("mask_two", IDX_MASK_TWO, RST_MASK_TWO);
        rdchk("hyst", IDX_HYST, RST_HYST);
        rdchk("irq_mask", IDX_IRQ_MASK, RST_IRQ_MASK);
        rdchk("unmapped", 6'h3F, 32'h0);
        wb(1'b1, IDX_ALARM_ONE, 32'hFFFF_FFFF);
        rdchk("status_ro", IDX_ALARM_ONE, 32'h0);
        for (c = 0; c < 5; c++) lim1[c] = RST_LIMIT;
        lim2 = lim1;
        // A set mask bit blocks its event from the pin, so zero enables all of them.
        {hy, m1, m2, st1, st2, irqs, irqm} = {RST_HYST, RST_MASK_ONE, RST_MASK_TWO, 30'h0};
        wb(1'b1, IDX_IRQ_MASK, 32'h0000_0000);
        for (c = 0; c < 5; c++) foreach (CORNER[j]) step(3'(c), CORNER[j]);
        for (c = 0; c < 7; c++) begin
            rnd = lfsr(rnd);
            v = {1'b0, rnd[6:0]} + 8'h20;
            wb(1'b1, IDX_LIM_LOCAL + 6'(c), {24'h0, v});
            if (c < 5) lim1[c] = v;
            else lim2[c - 4] = v;
        end
        {lim2[0], lim2[3], lim2[4]} = {lim1[0], lim1[3], lim1[4]};
        for (i = 0; i < 200; i++) begin
            rnd = lfsr(rnd);
            if (i % 25 == 0) begin
                {m1, m2, hy, irqm} = {rnd[4:0], rnd[9:5], 4'h0, rnd[13:10], rnd[15:6]};
                wb(1'b1, IDX_MASK_ONE, {27'h0, m1});
                wb(1'b1, IDX_MASK_TWO, {27'h0, m2});
                wb(1'b1, IDX_HYST, {24'h0, hy});
                wb(1'b1, IDX_IRQ_MASK, {22'h0, irqm});
                rnd = lfsr(rnd);
            end
            c = rnd % 5;
            step(3'(c), (rnd[0] ? lim2[c] : lim1[c]) + 8'(rnd[15:11]) - 8'h10);
        end
        end_of_test();
    end
endmodule : cta_alarm_status_tb_top
